// >>> hw/scp_pkg.sv
// package: constants, types and helpers of the serial configuration command port
package scp_pkg;

    typedef enum logic [1:0] {SCP_STOP, SCP_RUN, SCP_POLL, SCP_MODBUS} scp_mode_t;

    typedef struct packed {
        logic [7:0] baud_h;
        logic [1:0] parity;
        logic [3:0] data_bits;
        logic [1:0] stop_bits;
    } scp_line_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } scp_apb_t;

    localparam logic [7:0] OFF_CMD    = 8'h00;
    localparam logic [7:0] OFF_RESULT = 8'h04;
    localparam logic [7:0] OFF_ACTIVE = 8'h08;
    localparam logic [7:0] OFF_STORED = 8'h0C;
    localparam logic [7:0] OFF_ADRDLY = 8'h10;
    localparam logic [7:0] OFF_UPTIME = 8'h14;

    localparam logic [3:0] OP_SMODE   = 4'h1;
    localparam logic [3:0] OP_SERI    = 4'h2;
    localparam logic [3:0] OP_ADDR    = 4'h3;
    localparam logic [3:0] OP_SDELAY  = 4'h4;
    localparam logic [3:0] OP_OPEN    = 4'h5;
    localparam logic [3:0] OP_CLOSE   = 4'h6;
    localparam logic [3:0] OP_TIME    = 4'h7;
    localparam logic [3:0] OP_RESET   = 4'h8;
    localparam logic [3:0] OP_FACTORY = 4'h9;
    localparam logic [3:0] OP_SEND    = 4'hA;
    localparam logic [3:0] OP_STOPOUT = 4'hB;

    localparam logic [1:0] RES_OK      = 2'h0;
    localparam logic [1:0] RES_REJECT  = 2'h1;
    localparam logic [1:0] RES_IGNORED = 2'h2;

    localparam logic [3:0] RPL_NONE   = 4'h0;
    localparam logic [3:0] RPL_VALUE  = 4'h1;
    localparam logic [3:0] RPL_OPENED = 4'h2;
    localparam logic [3:0] RPL_CLOSED = 4'h3;
    localparam logic [3:0] RPL_TIME   = 4'h4;
    localparam logic [3:0] RPL_SEND   = 4'h5;
    localparam logic [3:0] RPL_MODBUS = 4'h6;

    localparam scp_line_t  DEF_LINE  = '{8'hC0, 2'h0, 4'h8, 2'h1};
    localparam scp_mode_t  DEF_MODE  = SCP_STOP;
    localparam logic [7:0] DEF_ADDR  = 8'h00;
    localparam logic [7:0] DEF_DELAY = 8'h0A;

    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned DELAY_STEP_MS = 4;
    localparam int unsigned DELAY_STEP_CYC = CLK_HZ / 1000 * DELAY_STEP_MS;
    localparam int unsigned ESC_WAIT_S    = 5;
    localparam int unsigned ESC_WAIT_CYC  = ESC_WAIT_S * CLK_HZ;
    localparam int unsigned SEC_CYC       = CLK_HZ;

    localparam logic [7:0]  MB_FUNC_READ = 8'h03;
    localparam logic [3:0]  MB_REQ_LEN   = 4'h8;
    localparam logic [15:0] MB_CRC_INIT  = 16'hFFFF;
    localparam logic [15:0] MB_CRC_POLY  = 16'hA001;
    localparam logic [7:0]  CH_HASH      = 8'h23;
    localparam logic [7:0]  CH_CR        = 8'h0D;
    localparam logic [7:0]  TIME_WRAP    = 8'h3B;

    function automatic logic [15:0] scp_crc(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++)
        begin
            c = c[0] ? ((c >> 1) ^ MB_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

endpackage

// >>> hw/scp_port.sv
// serial configuration command port: command execution, session, uptime, modbus, escape
`timescale 1ns/1ps
module scp_port
    import scp_pkg::*;
#(
    parameter int unsigned DELAY_CYC = DELAY_STEP_CYC,
    parameter int unsigned ESC_CYC   = ESC_WAIT_CYC,
    parameter int unsigned SECOND    = SEC_CYC
)(
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire scp_apb_t    apb_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    input  wire logic        mb_valid_i,
    input  wire logic [7:0]  mb_byte_i,
    input  wire logic        mb_end_i,
    input  wire logic        svc_attach_i,
    input  wire logic        svc_valid_i,
    input  wire logic [7:0]  svc_byte_i,
    output scp_line_t        line_o,
    output scp_mode_t        mode_o,
    output logic             reply_go_o,
    output logic [3:0]       reply_code_o,
    output logic [15:0]      mb_start_o,
    output logic [15:0]      mb_count_o,
    output logic             soft_restart_o
);

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    scp_mode_t   act_mode;
    scp_mode_t   sto_mode;
    scp_line_t   act_line;
    scp_line_t   sto_line;
    logic [7:0]  sto_addr;
    logic [7:0]  sto_delay;
    logic        session;
    logic        escaped;
    logic [1:0]  res_result;
    logic [3:0]  res_reply;
    logic [7:0]  res_value;
    logic [7:0]  up_s;
    logic [7:0]  up_m;
    logic [7:0]  up_h;
    logic [31:0] sec_cnt;
    logic        pending;
    logic [7:0]  dly_units;
    logic [31:0] dly_sub;
    logic [3:0]  mb_len;
    logic [15:0] mb_crc;
    logic [7:0]  mb_buf [6];
    logic [31:0] esc_cnt;
    logic        hash_seen;

    logic        cmd_wr;
    logic [3:0]  op;
    logic        has_arg;
    logic [7:0]  arg_a;
    logic [7:0]  arg_b;
    logic [7:0]  arg_c;
    logic        own;
    logic        allow;
    logic        seri_ok;
    logic        do_mode;
    logic        do_seri;
    logic        do_addr;
    logic        do_delay;
    logic        do_open;
    logic        do_close;
    logic        do_reset;
    logic        do_fact;
    logic        do_stop;
    logic [1:0]  next_result;
    logic [3:0]  next_reply;
    logic [7:0]  next_value;
    logic        mb_listen;
    logic        mb_hit;
    logic        esc_armed;
    logic        restart;
    logic        reply_start;

    assign cmd_wr  = apb_i.psel & apb_i.penable & apb_i.pwrite & (apb_i.paddr == OFF_CMD);
    assign op      = apb_i.pwdata[3:0];
    assign has_arg = apb_i.pwdata[4];
    assign arg_a   = apb_i.pwdata[15:8];
    assign arg_b   = apb_i.pwdata[23:16];
    assign arg_c   = apb_i.pwdata[31:24];
    assign own     = has_arg & (arg_a == sto_addr);

    always_comb
    begin
        unique case (arg_a)
            8'h03, 8'h06, 8'h0C, 8'h18, 8'h30, 8'h60, 8'hC0: seri_ok = 1'b1;
            default: seri_ok = 1'b0;
        endcase
        seri_ok = seri_ok & (arg_b[1:0] != 2'h3) & (arg_b[7:2] == 6'h00)
                & ((arg_c[3:0] == 4'h7) | (arg_c[3:0] == 4'h8))
                & ((arg_c[7:4] == 4'h1) | (arg_c[7:4] == 4'h2));
    end

    always_comb
    begin
        if (act_mode == SCP_MODBUS && !escaped)
            allow = (op == OP_ADDR);
        else if (act_mode == SCP_RUN)
            allow = (op == OP_STOPOUT);
        else if (act_mode == SCP_POLL && !session)
            allow = ((op == OP_SEND) || (op == OP_OPEN)) && own;
        else
            allow = 1'b1;
    end

    always_comb
    begin
        next_result = RES_OK;
        next_reply  = RPL_NONE;
        next_value  = 8'h00;
        do_mode     = 1'b0;
        do_seri     = 1'b0;
        do_addr     = 1'b0;
        do_delay    = 1'b0;
        do_open     = 1'b0;
        do_close    = 1'b0;
        do_reset    = 1'b0;
        do_fact     = 1'b0;
        do_stop     = 1'b0;
        if (!allow)
            next_result = (act_mode == SCP_MODBUS) ? RES_REJECT : RES_IGNORED;
        else
        begin
            unique case (op)
                OP_SMODE:
                begin
                    do_mode    = has_arg;
                    next_reply = RPL_VALUE;
                    next_value = has_arg ? {6'h00, arg_a[1:0]} : {6'h00, sto_mode};
                end
                OP_SERI:
                begin
                    do_seri     = has_arg & seri_ok;
                    next_result = (has_arg & !seri_ok) ? RES_REJECT : RES_OK;
                    next_reply  = (has_arg & !seri_ok) ? RPL_NONE : RPL_VALUE;
                    next_value  = sto_line.baud_h;
                end
                OP_ADDR:
                begin
                    do_addr    = has_arg;
                    next_reply = RPL_VALUE;
                    next_value = has_arg ? arg_a : sto_addr;
                end
                OP_SDELAY:
                begin
                    do_delay   = has_arg;
                    next_reply = RPL_VALUE;
                    next_value = has_arg ? arg_a : sto_delay;
                end
                OP_OPEN:
                begin
                    do_open     = own;
                    next_result = own ? RES_OK : RES_IGNORED;
                    next_reply  = own ? RPL_OPENED : RPL_NONE;
                    next_value  = sto_addr;
                end
                OP_CLOSE:
                begin
                    do_close   = 1'b1;
                    next_reply = RPL_CLOSED;
                end
                OP_TIME:    next_reply = RPL_TIME;
                OP_RESET:   do_reset = 1'b1;
                OP_FACTORY: do_fact = 1'b1;
                OP_SEND:    next_reply = RPL_SEND;
                OP_STOPOUT: do_stop = 1'b1;
                default:    next_result = RES_REJECT;
            endcase
        end
    end

    assign restart = cmd_wr & do_reset;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            act_mode <= DEF_MODE;
            act_line <= DEF_LINE;
        end
        else if (restart)
        begin
            act_mode <= sto_mode;
            act_line <= sto_line;
        end
        else if (cmd_wr & do_stop & (act_mode == SCP_RUN))
            act_mode <= SCP_STOP;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || (cmd_wr & do_fact))
        begin
            sto_mode  <= DEF_MODE;
            sto_line  <= DEF_LINE;
            sto_addr  <= DEF_ADDR;
            sto_delay <= DEF_DELAY;
        end
        else if (cmd_wr)
        begin
            if (do_mode)
                sto_mode <= scp_mode_t'(arg_a[1:0]);
            if (do_seri)
                sto_line <= '{arg_a, arg_b[1:0], arg_c[3:0], arg_c[5:4]};
            if (do_addr)
                sto_addr <= arg_a;
            if (do_delay)
                sto_delay <= arg_a;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || restart)
            session <= 1'b0;
        else if (cmd_wr & do_open & (act_mode == SCP_POLL))
            session <= 1'b1;
        else if (cmd_wr & do_close)
            session <= 1'b0;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            res_result <= RES_OK;
            res_reply  <= RPL_NONE;
            res_value  <= 8'h00;
        end
        else if (cmd_wr)
        begin
            res_result <= next_result;
            res_reply  <= next_reply;
            res_value  <= next_value;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || restart)
        begin
            sec_cnt <= 32'h0000_0000;
            up_s    <= 8'h00;
            up_m    <= 8'h00;
            up_h    <= 8'h00;
        end
        else if (sec_cnt == 32'(SECOND - 1))
        begin
            sec_cnt <= 32'h0000_0000;
            up_s    <= (up_s == TIME_WRAP) ? 8'h00 : up_s + 8'h01;
            if (up_s == TIME_WRAP)
                up_m <= (up_m == TIME_WRAP) ? 8'h00 : up_m + 8'h01;
            if (up_s == TIME_WRAP && up_m == TIME_WRAP)
                up_h <= up_h + 8'h01;
        end
        else
            sec_cnt <= sec_cnt + 32'h0000_0001;
    end

    assign mb_listen = (act_mode == SCP_MODBUS) & !escaped & (sto_addr != 8'h00);
    assign mb_hit    = mb_listen & mb_end_i & (mb_len == MB_REQ_LEN) & (mb_crc == 16'h0000)
                     & (mb_buf[0] == sto_addr) & (mb_buf[1] == MB_FUNC_READ);

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || mb_end_i || !mb_listen)
        begin
            mb_len <= 4'h0;
            mb_crc <= MB_CRC_INIT;
        end
        else if (mb_valid_i)
        begin
            mb_len <= (mb_len == 4'hF) ? mb_len : mb_len + 4'h1;
            mb_crc <= scp_crc(mb_crc, mb_byte_i);
            if (mb_len < 4'h6)
                mb_buf[mb_len[2:0]] <= mb_byte_i;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            mb_start_o <= 16'h0000;
            mb_count_o <= 16'h0000;
        end
        else if (mb_hit)
        begin
            mb_start_o <= {mb_buf[2], mb_buf[3]};
            mb_count_o <= {mb_buf[4], mb_buf[5]};
        end
    end

    assign esc_armed = (esc_cnt == 32'(ESC_CYC));

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || !svc_attach_i || act_mode != SCP_MODBUS)
            esc_cnt <= 32'h0000_0000;
        else if (!esc_armed)
            esc_cnt <= esc_cnt + 32'h0000_0001;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || restart)
        begin
            escaped   <= 1'b0;
            hash_seen <= 1'b0;
        end
        else if (svc_valid_i && esc_armed && !escaped)
        begin
            hash_seen <= (svc_byte_i == CH_HASH);
            if (hash_seen && svc_byte_i == CH_CR)
                escaped <= 1'b1;
        end
    end

    assign reply_start = (cmd_wr & (next_reply != RPL_NONE)) | mb_hit;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || restart)
        begin
            pending      <= 1'b0;
            dly_units    <= 8'h00;
            dly_sub      <= 32'h0000_0000;
            reply_go_o   <= 1'b0;
            reply_code_o <= RPL_NONE;
        end
        else if (reply_start)
        begin
            pending      <= 1'b1;
            dly_units    <= (cmd_wr & do_delay) ? arg_a : sto_delay;
            dly_sub      <= 32'h0000_0000;
            reply_go_o   <= 1'b0;
            reply_code_o <= mb_hit ? RPL_MODBUS : next_reply;
        end
        else if (pending && dly_units == 8'h00)
        begin
            pending    <= 1'b0;
            reply_go_o <= 1'b1;
        end
        else
        begin
            reply_go_o <= 1'b0;
            if (pending && dly_sub == 32'(DELAY_CYC - 1))
            begin
                dly_sub   <= 32'h0000_0000;
                dly_units <= dly_units - 8'h01;
            end
            else if (pending)
                dly_sub <= dly_sub + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            soft_restart_o <= 1'b0;
        else
            soft_restart_o <= restart;
    end

    assign line_o   = act_line;
    assign mode_o   = act_mode;
    assign pready_o = 1'b1;

    always_comb
    begin
        pslverr_o = 1'b0;
        unique case (apb_i.paddr)
            OFF_CMD:    prdata_o = 32'h0000_0000;
            OFF_RESULT: prdata_o = {15'h0000, pending, res_value, res_reply, 2'h0, res_result};
            OFF_ACTIVE: prdata_o = {act_line, 9'h000, !mb_listen, escaped, session, 2'h0,
                                    act_mode};
            OFF_STORED: prdata_o = {sto_line, 14'h0000, sto_mode};
            OFF_ADRDLY: prdata_o = {16'h0000, sto_delay, sto_addr};
            OFF_UPTIME: prdata_o = {8'h00, up_h, up_m, up_s};
            default:
            begin
                prdata_o  = 32'h0000_0000;
                pslverr_o = apb_i.psel & apb_i.penable;
            end
        endcase
    end

    restart_mode_a: assert property (restart |=> act_mode == $past(sto_mode))
        else $error("restart did not load stored mode");
    baud_reject_a: assert property (cmd_wr && allow && op == OP_SERI && has_arg && !seri_ok
        |=> sto_line == $past(sto_line) && res_result == RES_REJECT)
        else $error("bad serial setting accepted");
    line_hold_a: assert property (cmd_wr && do_seri |=> act_line == $past(act_line))
        else $error("line changed before restart");
    addr_report_a: assert property (cmd_wr && allow && op == OP_ADDR && !has_arg
        |=> res_value == $past(sto_addr) && res_reply == RPL_VALUE)
        else $error("address not reported");
    delay_zero_a: assert property (reply_start && !cmd_wr && sto_delay == 8'h00
        ##1 !reply_start && !restart |=> reply_go_o)
        else $error("zero delay reply late");
    delay_one_a: assert property (reply_start && !cmd_wr && sto_delay == 8'h01
        |=> !reply_go_o [*2])
        else $error("reply before one delay step");
    open_ack_a: assert property (cmd_wr && act_mode == SCP_POLL && op == OP_OPEN && own
        |=> session && res_reply == RPL_OPENED)
        else $error("open not acknowledged");
    close_ack_a: assert property (cmd_wr && allow && op == OP_CLOSE
        |=> !session && res_reply == RPL_CLOSED)
        else $error("close not acknowledged");
    factory_set_a: assert property (cmd_wr && do_fact
        |=> sto_addr == DEF_ADDR && sto_delay == DEF_DELAY && sto_line == DEF_LINE)
        else $error("factory restore incomplete");
    modbus_lock_a: assert property (cmd_wr && act_mode == SCP_MODBUS && !escaped
        && op != OP_ADDR |=> sto_mode == $past(sto_mode) && sto_line == $past(sto_line))
        else $error("configuration changed in modbus mode");
    escape_cause_a: assert property ($rose(escaped) |-> $past(esc_armed) && $past(hash_seen))
        else $error("escape without armed sequence");
    offline_quiet_a: assert property (mb_end_i && sto_addr == 8'h00
        |=> $stable(mb_start_o) && $stable(mb_count_o))
        else $error("offline station answered");
    poll_ignore_a: assert property (cmd_wr && act_mode == SCP_POLL && !session
        && op == OP_TIME |=> res_result == RES_IGNORED && !reply_go_o)
        else $error("foreign poll command answered");

    open_cov_c:   cover property (cmd_wr && do_open ##1 session);
    modbus_cov_c: cover property (mb_hit);
    escape_cov_c: cover property ($rose(escaped));
    reply_cov_c:  cover property (reply_go_o);

endmodule

// >>> tb/scp_host.sv
// partner model: modbus master and service terminal
`timescale 1ns/1ps
module scp_host
    import scp_pkg::*;
(
    input  wire logic       clk_sys_i,
    output logic            mb_valid_o,
    output logic [7:0]      mb_byte_o,
    output logic            mb_end_o,
    output logic            svc_attach_o,
    output logic            svc_valid_o,
    output logic [7:0]      svc_byte_o
);
    initial
    begin
        {mb_valid_o, mb_end_o, svc_attach_o, svc_valid_o} = '0;
        {mb_byte_o, svc_byte_o} = '0;
    end
    // whole frame, byte lines inverted when idle
    task automatic mb(input logic [63:0] f);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge clk_sys_i);
            mb_valid_o <= 1'b1;
            mb_byte_o  <= f[i*8+:8];
        end
        @(posedge clk_sys_i);
        mb_valid_o <= 1'b0;
        mb_byte_o  <= ~f[7:0];
        mb_end_o   <= 1'b1;
        @(posedge clk_sys_i);
        mb_end_o   <= 1'b0;
    endtask
    // attach, wait quiet time, hash then return
    task automatic esc(input int n);
        @(posedge clk_sys_i);
        svc_attach_o <= 1'b1;
        repeat (n) @(posedge clk_sys_i);
        svc_valid_o <= 1'b1;
        svc_byte_o  <= CH_HASH;
        @(posedge clk_sys_i);
        svc_byte_o  <= CH_CR;
        @(posedge clk_sys_i);
        svc_valid_o  <= 1'b0;
        svc_byte_o   <= ~CH_CR;
        svc_attach_o <= 1'b0;
    endtask
endmodule

// >>> tb/tb_scp_port.sv
// testbench of the serial configuration command port
`timescale 1ns/1ps
module tb_scp_port
    import scp_pkg::*;
;
    typedef struct {logic [3:0] code; int due;} scp_exp_t;
    logic        clk_sys_i = 0;
    logic        rst_i = 1;
    scp_apb_t    apb = '0;
    logic        rdy, err, ev, mbv, mbe, sva, svv, go, srst;
    logic [31:0] prd, rv;
    logic [31:0] lfsr = 32'h02E566A6;
    logic [7:0]  mbb, svb;
    logic [3:0]  code;
    logic [15:0] mbs, mbc;
    scp_line_t   line;
    scp_mode_t   mode;
    int          bad_count = 0, cmp_count = 0, cyc = 0, t_cmd, restarts = 0;
    scp_exp_t    q[$];
    logic [31:0] seri_tab [13] = '{32'h1800_0300, 32'h1800_0600, 32'h1800_0C00,
        32'h1800_1800, 32'h1800_3000, 32'h1800_C000, 32'h1800_0701, 32'h1800_0001,
        32'h1803_6001, 32'h1901_6001, 32'h3801_6001, 32'h2702_6000, 32'h1801_6000};

    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) cyc <= cyc + 1;
    always @(posedge clk_sys_i)
        if (srst === 1'b1)
            restarts <= restarts + 1;

    scp_port #(.DELAY_CYC(4), .ESC_CYC(50), .SECOND(10)) scp_port_inst (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .apb_i(apb), .pready_o(rdy), .prdata_o(prd), .pslverr_o(err),
        .mb_valid_i(mbv), .mb_byte_i(mbb), .mb_end_i(mbe), .svc_attach_i(sva),
        .svc_valid_i(svv), .svc_byte_i(svb), .line_o(line), .mode_o(mode),
        .reply_go_o(go), .reply_code_o(code), .mb_start_o(mbs), .mb_count_o(mbc),
        .soft_restart_o(srst));
    scp_host scp_host_inst (.clk_sys_i(clk_sys_i), .mb_valid_o(mbv), .mb_byte_o(mbb),
        .mb_end_o(mbe), .svc_attach_o(sva), .svc_valid_o(svv), .svc_byte_o(svb));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // only the watchdog ends a wait for pready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_sys_i);
        apb.penable <= 1'b1;
        do
        begin
            @(posedge clk_sys_i);
        end while (rdy !== 1'b1);
        rv = prd;
        ev = err;
        if (w)
            t_cmd = cyc;
        apb <= '{1'b0, 1'b0, w, ~a, ~d};
    endtask
    task automatic run(input logic [31:0] w);
        bus(1'b1, OFF_CMD, w);
        bus(1'b0, OFF_RESULT, 32'h0);
    endtask
    // expected reply noted first, monitor below takes it off
    task automatic rep(input logic [3:0] c, input int d);
        q.push_back('{c, d});
        for (int i = 0; i < 300 && q.size() > 0; i++)
            @(posedge clk_sys_i);
        chk("reply_seen", q.size(), 0);
    endtask
    always @(posedge clk_sys_i)
        if (go === 1'b1 && q.size() > 0)
        begin
            chk("reply_code", code, q[0].code);
            if (q[0].due >= 0)
                chk("reply_time", cyc, q[0].due);
            void'(q.pop_front());
        end
    task automatic results();
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        bad_count++;
        results();
    end
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        bus(1'b0, OFF_ACTIVE, 0);
        chk("active", rv, 32'hC021_0040);
        bus(1'b0, OFF_ADRDLY, 0);
        chk("adrdly", rv, 32'h0000_0A00);
        run(32'h0214);
        run(32'h0513);
        run(32'h0003);
        chk("addr_q", rv[15:4], {8'h05, RPL_VALUE});
        rep(RPL_VALUE, t_cmd + 10);
        foreach (seri_tab[i])
        begin
            run({seri_tab[i][31:8], 8'h12});
            chk("seri", rv[1:0], seri_tab[i][1:0]);
        end
        run(32'h0211);
        bus(1'b0, OFF_STORED, 0);
        chk("stored", rv, 32'h6061_0002);
        bus(1'b0, OFF_ACTIVE, 0);
        chk("active", rv, 32'hC021_0040);
        run(32'h07);
        rep(RPL_TIME, t_cmd + 10);
        run(32'h08);
        bus(1'b0, OFF_UPTIME, 0);
        chk("uptime", rv, 0);
        bus(1'b0, OFF_ACTIVE, 0);
        chk("active", rv, 32'h6061_0042);
        bus(1'b0, OFF_ADRDLY, 0);
        chk("adrdly", {rv[15:0], line}, 32'h0205_6061);
        run(32'h07);
        chk("res", rv[1:0], RES_IGNORED);
        run(32'h0615);
        chk("res", rv[1:0], RES_IGNORED);
        run(32'h0515);
        rep(RPL_OPENED, t_cmd + 10);
        bus(1'b0, OFF_ACTIVE, 0);
        chk("active", rv, 32'h6061_0052);
        run(32'h06);
        rep(RPL_CLOSED, t_cmd + 10);
        run(32'h07);
        chk("res", rv[1:0], RES_IGNORED);
        run(32'h0515);
        rep(RPL_OPENED, t_cmd + 10);
        // zero delay so the modbus reply follows at once
        run(32'h0014);
        run(32'h0311);
        run(32'h0113);
        run(32'h08);
        run(32'h0013);
        bus(1'b0, OFF_ACTIVE, 0);
        chk("active", rv, 32'h6061_0043);
        scp_host_inst.mb(64'h0103_0004_0002_85CA);
        chk("mb_off", {mbs, mbc}, 32'h0000_0000);
        run(32'h0113);
        chk("res", rv[1:0], RES_OK);
        run(32'h1801_6012);
        chk("res", rv[1:0], RES_REJECT);
        scp_host_inst.mb(64'h0103_0004_0002_85CA);
        rep(RPL_MODBUS, -1);
        chk("mb_req", {mbs, mbc}, 32'h0004_0002);
        scp_host_inst.esc(60);
        bus(1'b0, OFF_ACTIVE, 0);
        chk("active", rv, 32'h6061_0063);
        run(32'h0111);
        run(32'h08);
        bus(1'b0, OFF_ACTIVE, 0);
        chk("active", rv, 32'h6061_0041);
        run(32'h07);
        chk("res", rv[1:0], RES_IGNORED);
        run(32'h0B);
        chk("mode", mode, SCP_STOP);
        run(32'h09);
        bus(1'b0, OFF_STORED, 0);
        chk("stored", rv, 32'hC021_0000);
        lfsr = lfsr_next(lfsr);
        bus(1'b1, OFF_ADRDLY, lfsr);
        bus(1'b0, {2'b01, lfsr[3:0], 2'b00}, lfsr);
        chk("unmapped", rv, 32'h0000_0000);
        chk("slverr", ev, 32'h0000_0001);
        bus(1'b0, OFF_ADRDLY, 0);
        chk("adrdly", rv, 32'h0000_0A00);
        chk("soft_restart", restarts, 3);
        results();
    end
endmodule
